// ===== tb/sgc_global_ctrl_assertions.sv
/*
 * Concurrent checks on the ports of the global control block, bound to it.
 * Assumes no write lands in the strap capture cycle.
 */
`timescale 1ns/1ps
`include "sgc_defines.svh"

module sgc_global_ctrl_assertions #(
    parameter int NPORT     = `SGC_NPORT,
    parameter int FLUSH_CYC = `SGC_FLUSH_CYC
) (
    input wire logic                               i_clk_sys,
    input wire logic                               i_reset_n,
    input wire logic                               i_ce,
    input wire sgc_pkg::sgc_req_type               i_req,
    input wire logic                               o_rvalid,
    input wire sgc_pkg::sgc_port_stat_type [NPORT-1:0] i_port_stat,
    input wire logic [NPORT-1:0]                   o_mib_flush,
    input wire logic [NPORT-1:0]                   o_mib_freeze,
    input wire logic                               i_mib_flush_done,
    input wire logic                               o_rmii_ref_falling,
    input wire logic                               o_aux_clock_output_en,
    input wire logic                               o_spi_read_falling,
    input wire logic [NPORT-1:0]                   o_port_indicator_one,
    input wire logic [NPORT-1:0]                   o_port_indicator_zero
);
    // Busy window plus two cycles of slack for the output to drop
    localparam int FL_MAX = FLUSH_CYC + 2;
    wire logic w08 = i_ce && i_req.wr && (i_req.addr == `SGC_OFF_MIB_CTRL);
    wire logic w0b = i_ce && i_req.wr && (i_req.addr == `SGC_OFF_CLK_IND);

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    // ****************************************
    // Register bus and control outputs
    // ****************************************
    a_read_latency: assert property (i_ce && i_req.rd ##1 i_ce |=> o_rvalid)
        else $error("read answer not two cycles after request");
    a_rvalid_cause: assert property (o_rvalid |-> $past(i_req.rd, 2))
        else $error("read answer without a request");
    a_freeze_mask: assert property (
        w08 |=> o_mib_freeze == ($past(i_req.wdata[6]) ? $past(i_req.wdata[4:0]) : '0))
        else $error("freeze outputs do not follow mask");
    a_flush_start: assert property (
        w08 && i_req.wdata[7] |-> ##2 (o_mib_flush == $past(i_req.wdata[4:0], 2)))
        else $error("flush outputs do not follow mask");
    a_flush_done_end: assert property (
        i_mib_flush_done && (|o_mib_flush) |-> ##[1:2] (o_mib_flush == '0))
        else $error("flush not ended by done");
    a_flush_bounded: assert property ($rose(|o_mib_flush) |-> ##[1:FL_MAX] (o_mib_flush == '0))
        else $error("flush outlives its cycle limit");
    a_rmii_edge: assert property (w0b |=> o_rmii_ref_falling == $past(i_req.wdata[6]))
        else $error("reference edge select wrong");
    a_aux_enable: assert property (w0b |=> o_aux_clock_output_en == $past(i_req.wdata[1]))
        else $error("aux clock enable wrong");
    a_spi_edge: assert property (w0b |=> o_spi_read_falling == $past(i_req.wdata[0]))
        else $error("spi read edge select wrong");
    a_idle_lamps_off: assert property (
        (!i_port_stat[0].link && !i_port_stat[0].act) [*2] |->
        o_port_indicator_one[0] && o_port_indicator_zero[0])
        else $error("lamp lit on idle port");

    c_flush: cover property (w08 && i_req.wdata[7]);
    c_flush_done: cover property (i_mib_flush_done && (|o_mib_flush));
    c_blink: cover property ($fell(o_port_indicator_one[2]));
endmodule : sgc_global_ctrl_assertions

bind sgc_global_ctrl sgc_global_ctrl_assertions #(.NPORT(NPORT), .FLUSH_CYC(FLUSH_CYC)) u_chk (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_req(i_req), .o_rvalid(o_rvalid),
    .i_port_stat(i_port_stat), .o_mib_flush(o_mib_flush), .o_mib_freeze(o_mib_freeze),
    .i_mib_flush_done(i_mib_flush_done), .o_rmii_ref_falling(o_rmii_ref_falling),
    .o_aux_clock_output_en(o_aux_clock_output_en), .o_spi_read_falling(o_spi_read_falling),
    .o_port_indicator_one(o_port_indicator_one), .o_port_indicator_zero(o_port_indicator_zero));

// ===== tb/tb_top.sv
/*
 * Self-checking bench for the global control block.
 * Assumes the checker is compiled alongside; short blink and flush counts.
 */
`timescale 1ns/1ps
`include "sgc_defines.svh"

module tb_top;
    localparam int BLINK = 4;
    localparam int FLUSH = 4;
    logic                             clk = 1'b0;
    logic                             rst_n = 1'b0;
    logic                             ce = 1'b1;
    logic                             strap = 1'b1;
    logic                             done = 1'b0;
    sgc_pkg::sgc_req_type             req = '0;
    sgc_pkg::sgc_port_stat_type [4:0] stat = '0;
    logic [7:0]                       rdata;
    logic [7:0]                       got;
    logic                             rvalid, rmii, aux, spi;
    logic [4:0]                       flush, freeze, ind1, ind0;
    logic [1:0]                       seen;
    logic [31:0]                      rows [8];
    logic [7:0]                       rst_val [4];
    int                               fails = 0;
    int                               total_checks = 0;

    always #5 clk = ~clk;

    sgc_global_ctrl #(.NPORT(5), .BLINK_CYC(BLINK), .FLUSH_CYC(FLUSH)) DUT (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_ce(ce), .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid),
        .i_aux_clock_strap_pin(strap), .i_port_stat(stat), .o_mib_flush(flush), .o_mib_freeze(freeze),
        .i_mib_flush_done(done), .o_rmii_ref_falling(rmii), .o_aux_clock_output_en(aux),
        .o_spi_read_falling(spi), .o_port_indicator_one(ind1), .o_port_indicator_zero(ind0));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // Extra idle edge keeps back-to-back calls from driving req twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        #1 req = '0;
        @(posedge clk);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        #1 req = '0;
        for (n = 0; n < 4 && rvalid !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 4) begin
            fails++;
            $display("MISMATCH at %0t: no read answer", $time);
            give_verdict;
        end else begin
            d = rdata;
            @(posedge clk);
            #1;
        end
    endtask : rd

    task automatic do_reset(input logic s);
        rst_n = 1'b0;
        strap = s;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask : do_reset

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        // Rows: address, write data, read back, {rmii, aux, spi, freeze}
        rows = '{32'h085f5f1f, 32'h09ff401f, 32'h0aff001f, 32'h0bff73ff,
                 32'h0cff00ff, 32'h081f1fe0, 32'h0b404080, 32'h084a4a8a};
        rst_val = '{8'h00, 8'h40, 8'h00, 8'h00};
        #1;
        do_reset(1'b1);
        rd(8'h0b, got);
        chk(got, 8'h02);
        chk({7'h00, aux}, 8'h01);
        do_reset(1'b0);
        chk({3'h0, ind1 & ind0}, 8'h1f);
        for (int i = 0; i < 4; i++) begin
            rd(8'h08 + i[7:0], got);
            chk(got, rst_val[i]);
        end
        for (int i = 0; i < 8; i++) begin
            wr(rows[i][31:24], rows[i][23:16]);
            chk({rmii, aux, spi, freeze}, rows[i][7:0]);
            rd(rows[i][31:24], got);
            chk(got, rows[i][15:8]);
        end
        // Flush ended early by the counters
        wr(8'h08, 8'h95);
        chk({3'h0, flush}, 8'h15);
        done = 1'b1;
        @(posedge clk);
        #1 done = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({3'h0, flush}, 8'h00);
        rd(8'h08, got);
        chk(got, 8'h15);
        // Flush with no done pulse must still end
        wr(8'h08, 8'h88);
        chk({3'h0, flush}, 8'h08);
        repeat (FLUSH + 2) @(posedge clk);
        #1;
        chk({3'h0, flush}, 8'h00);
        rd(8'h08, got);
        chk(got, 8'h08);
        // Port 1 linked at 100 half, port 2 linked at 10 full
        stat[0] = '{link: 1'b1, act: 1'b0, speed_100: 1'b1, full_duplex: 1'b0};
        stat[1] = '{link: 1'b1, act: 1'b0, speed_100: 1'b0, full_duplex: 1'b1};
        for (int m = 0; m < 4; m++) begin
            wr(8'h0b, {2'b00, m[1:0], 4'h0});
            repeat (2) @(posedge clk);
            #1;
            chk({3'h0, ind0}, 8'h1c);
            chk({3'h0, ind1}, {3'h0, 3'b111, ~m[1], m[1:0] != 2'b00});
        end
        // Activity alone must blink in mode 01
        stat[2] = '{link: 1'b0, act: 1'b1, speed_100: 1'b0, full_duplex: 1'b0};
        wr(8'h0b, 8'h10);
        seen = 2'b00;
        repeat (4 * BLINK) begin
            @(posedge clk);
            #1;
            if (ind1[2] === 1'b0) seen[0] = 1'b1;
            if (ind1[2] === 1'b1) seen[1] = 1'b1;
        end
        chk({6'h00, seen}, 8'h03);
        // Clock enable low: the write must not be taken
        ce = 1'b0;
        wr(8'h0b, 8'h01);
        chk({7'h00, spi}, 8'h00);
        ce = 1'b1;
        rd(8'h0b, got);
        chk(got, 8'h10);
        give_verdict;
    end

    initial begin
        #500000;
        fails++;
        $display("MISMATCH at %0t: run limit reached", $time);
        give_verdict;
    end
endmodule : tb_top

// ===== verilog/sgc_defines.svh
/*
 * Constants for the global control block: register offsets, field positions,
 * reset values and timing counts.
 * Assumes inclusion by bare name from package and modules.
 */
`ifndef SGC_DEFINES_SVH
`define SGC_DEFINES_SVH

`define SGC_ADDR_W          8
`define SGC_DATA_W          8
`define SGC_NPORT           5

`define SGC_OFF_MIB_CTRL    8'h08
`define SGC_OFF_FTEST_A     8'h09
`define SGC_OFF_FTEST_B     8'h0a
`define SGC_OFF_CLK_IND     8'h0b

`define SGC_RST_MIB_CTRL    8'h00
`define SGC_RST_FTEST_A     8'h40
`define SGC_RST_FTEST_B     8'h00
`define SGC_RST_CLK_IND     8'h00

`define SGC_BIT_FLUSH       7
`define SGC_BIT_FREEZE      6
`define SGC_MASK_HI         4
`define SGC_MASK_LO         0

`define SGC_BIT_RMII_EDGE   6
`define SGC_IND_MODE_HI     5
`define SGC_IND_MODE_LO     4
`define SGC_BIT_AUX_EN      1
`define SGC_BIT_SPI_EDGE    0

`define SGC_MIB_CTRL_WMASK  8'hdf
`define SGC_CLK_IND_WMASK   8'h73

`define SGC_IND_ON          1'b0
`define SGC_IND_OFF         1'b1

`define SGC_BLINK_MS        100
`define SGC_CLK_MHZ         100
`define SGC_BLINK_CYC       (`SGC_BLINK_MS * 1000 * `SGC_CLK_MHZ)
`define SGC_FLUSH_CYC       36

`define SGC_ZERO8           8'h00

`endif

// ===== verilog/sgc_global_ctrl.sv
/*
 * Global control registers 0x08 to 0x0b of a five-port switch: counter flush
 * and freeze, fifth-port reference clock edge, port indicators, auxiliary
 * clock enable and SPI read edge.
 * Assumes the SPI front end hands over one-cycle read/write strobes and
 * accepts read data two cycles after the read strobe.
 */
`timescale 1ns/1ps
`include "sgc_defines.svh"

// Behaviour
// - Flush bit clears counters of masked ports, then self-clears when done.
// - Freeze bit holds counters of masked ports; counting resumes when cleared.
// - Five mask bits pick ports; bit 4 is port 5, bit 0 port 1.
// - Config bit 6 picks falling (1) or rising (0) RMII sample edge.
// - Indicator outputs are low for lamp on, high for off.
// - Bits 5:4 choose the pair of indicator functions per port.
// - Link steady on, activity blinks, speed on at 100, duplex on full.
// - Bit 1 enables aux clock output; reset value taken from strap pin.
module sgc_global_ctrl #(
    parameter int NPORT     = `SGC_NPORT,
    parameter int BLINK_CYC = `SGC_BLINK_CYC,
    parameter int FLUSH_CYC = `SGC_FLUSH_CYC
) (
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_reset_n,
    input  wire logic                          i_ce,
    input  wire sgc_pkg::sgc_req_type          i_req,
    output logic      [`SGC_DATA_W-1:0]        o_rdata,
    output logic                               o_rvalid,
    input  wire logic                          i_aux_clock_strap_pin,
    input  wire sgc_pkg::sgc_port_stat_type [NPORT-1:0] i_port_stat,
    output logic      [NPORT-1:0]              o_mib_flush,
    output logic      [NPORT-1:0]              o_mib_freeze,
    input  wire logic                          i_mib_flush_done,
    output logic                               o_rmii_ref_falling,
    output logic                               o_aux_clock_output_en,
    output logic                               o_spi_read_falling,
    output logic      [NPORT-1:0]              o_port_indicator_one,
    output logic      [NPORT-1:0]              o_port_indicator_zero
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic [2:0] dec_addr(input logic [`SGC_ADDR_W-1:0] a);
        // Returns {hit, index}
        unique case (a)
            `SGC_OFF_MIB_CTRL: dec_addr = 3'h4;
            `SGC_OFF_FTEST_A:  dec_addr = 3'h5;
            `SGC_OFF_FTEST_B:  dec_addr = 3'h6;
            `SGC_OFF_CLK_IND:  dec_addr = 3'h7;
            default:           dec_addr = 3'h0;
        endcase
    endfunction : dec_addr

    logic [2:0] wdec;
    logic [2:0] rdec;
    assign wdec = dec_addr(i_req.addr);
    assign rdec = wdec;

    logic [`SGC_DATA_W-1:0] word0;
    logic [`SGC_DATA_W-1:0] word3;
    logic [`SGC_DATA_W-1:0] mem_rdata;

    // ****************************************************************
    // Strap capture and flush sequencing
    // ****************************************************************
    sgc_pkg::sgc_flush_state_type fl_state_r;
    sgc_pkg::sgc_flush_state_type fl_state_nxt;
    logic [15:0]            fl_cnt_r;
    logic [15:0]            fl_cnt_nxt;
    logic                   strap_done_r;
    logic                   strap_done_nxt;
    logic                   rd_pend_r;
    logic                   rd_pend_nxt;
    logic                   rvalid_r;
    logic                   rvalid_nxt;
    logic                   rhit_r;
    logic                   rhit_nxt;
    logic                   fl_clear;
    logic [2:0]             rsel_r;
    logic [2:0]             rsel_nxt;

    logic                   sw_we;
    logic                   we;
    logic [`SGC_DATA_W-1:0] wdata;
    logic [`SGC_DATA_W-1:0] aux_rst;

    assign sw_we = i_req.wr & wdec[2] & (wdec[1:0] == 2'h0 || wdec[1:0] == 2'h3);

    // Writes keep read-only bits at their stored value
    always_comb begin
        we    = sw_we;
        wdata = (wdec[1:0] == 2'h0)
              ? ((i_req.wdata & `SGC_MIB_CTRL_WMASK) | (word0 & ~`SGC_MIB_CTRL_WMASK))
              : ((i_req.wdata & `SGC_CLK_IND_WMASK)  | (word3 & ~`SGC_CLK_IND_WMASK));
        // Self-clear of flush; a fresh software flush write in that cycle wins
        if (fl_clear && !(sw_we && wdec[1:0] == 2'h0)) begin
            we    = 1'b1;
            wdata = word0 & ~(8'h01 << `SGC_BIT_FLUSH);
        end
        aux_rst = word3;
        aux_rst[`SGC_BIT_AUX_EN] = i_aux_clock_strap_pin;
    end

    always_comb begin
        fl_state_nxt   = fl_state_r;
        fl_cnt_nxt     = fl_cnt_r;
        fl_clear       = 1'b0;
        strap_done_nxt = 1'b1;
        rd_pend_nxt    = i_req.rd;
        // Read index is registered so data lines up with the answer strobe
        rsel_nxt       = rdec;
        rhit_nxt       = rsel_r[2];
        rvalid_nxt     = rd_pend_r;
        unique case (fl_state_r)
            sgc_pkg::SGC_FL_IDLE: begin
                if (word0[`SGC_BIT_FLUSH]) begin
                    fl_state_nxt = sgc_pkg::SGC_FL_BUSY;
                    fl_cnt_nxt   = 16'h0000;
                end
            end
            sgc_pkg::SGC_FL_BUSY: begin
                fl_cnt_nxt = fl_cnt_r + 16'h0001;
                // Done when counters report, or after a bounded sweep
                if (i_mib_flush_done || fl_cnt_r >= 16'(FLUSH_CYC - 1)) begin
                    if (sw_we && wdec[1:0] == 2'h3) begin
                        // One write port: let the config write land, clear next cycle
                        fl_cnt_nxt = 16'(FLUSH_CYC - 1);
                    end else begin
                        fl_clear     = 1'b1;
                        fl_state_nxt = sgc_pkg::SGC_FL_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fl_state_r   <= sgc_pkg::SGC_FL_IDLE;
            fl_cnt_r     <= 16'h0000;
            strap_done_r <= 1'b0;
            rd_pend_r    <= 1'b0;
            rhit_r       <= 1'b0;
            rsel_r       <= 3'h0;
            rvalid_r     <= 1'b0;
        end else if (i_ce) begin
            fl_state_r   <= fl_state_nxt;
            fl_cnt_r     <= fl_cnt_nxt;
            strap_done_r <= strap_done_nxt;
            rd_pend_r    <= rd_pend_nxt;
            rhit_r       <= rhit_nxt;
            rsel_r       <= rsel_nxt;
            rvalid_r     <= rvalid_nxt;
        end
    end

    sgc_regfile #(
        .DW         (`SGC_DATA_W)
    ) u_regs (
        .i_clk_sys  (i_clk_sys),
        .i_reset_n  (i_reset_n),
        .i_ce       (i_ce),
        .i_waddr    (wdec[1:0]),
        .i_we       (we),
        .i_wdata    (wdata),
        .i_aux_rst  (aux_rst),
        .i_load_aux (~strap_done_r),
        .i_raddr    (rsel_r[1:0]),
        .o_rdata    (mem_rdata),
        .o_word0    (word0),
        .o_word3    (word3)
    );

    // Unmapped reads answer zero
    assign o_rdata  = rhit_r ? mem_rdata : `SGC_ZERO8;
    assign o_rvalid = rvalid_r;

    // ****************************************************************
    // Counter control and clock selects
    // ****************************************************************
    logic [NPORT-1:0] mask;
    assign mask = word0[`SGC_MASK_HI:`SGC_MASK_LO];
    assign o_mib_flush  = (fl_state_r == sgc_pkg::SGC_FL_BUSY) ? mask : '0;
    assign o_mib_freeze = word0[`SGC_BIT_FREEZE] ? mask : '0;

    assign o_rmii_ref_falling    = word3[`SGC_BIT_RMII_EDGE];
    assign o_aux_clock_output_en = word3[`SGC_BIT_AUX_EN];
    assign o_spi_read_falling    = word3[`SGC_BIT_SPI_EDGE];

    // ****************************************************************
    // Port indicators
    // ****************************************************************
    // Shared blink phase keeps all lamps flashing in step
    logic [31:0] blink_cnt_r;
    logic [31:0] blink_cnt_nxt;
    logic        blink_r;
    logic        blink_nxt;
    logic [NPORT-1:0] ind1_r;
    logic [NPORT-1:0] ind1_nxt;
    logic [NPORT-1:0] ind0_r;
    logic [NPORT-1:0] ind0_nxt;

    always_comb begin
        blink_cnt_nxt = blink_cnt_r + 32'h0000_0001;
        blink_nxt     = blink_r;
        if (blink_cnt_r >= 32'(BLINK_CYC - 1)) begin
            blink_cnt_nxt = 32'h0000_0000;
            blink_nxt     = ~blink_r;
        end
    end

    sgc_pkg::sgc_ind_mode_type ind_mode;
    assign ind_mode = sgc_pkg::sgc_ind_mode_type'(word3[`SGC_IND_MODE_HI:`SGC_IND_MODE_LO]);

    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_ind
            logic lit_link;
            logic lit_lact;
            logic lit_act;
            logic lit_speed;
            logic lit_dup;
            always_comb begin
                lit_link  = i_port_stat[p].link;
                lit_act   = i_port_stat[p].act & blink_r;
                lit_lact  = i_port_stat[p].link & ~(i_port_stat[p].act & blink_r);
                lit_speed = i_port_stat[p].link & i_port_stat[p].speed_100;
                lit_dup   = i_port_stat[p].link & i_port_stat[p].full_duplex;
                unique case (ind_mode)
                    sgc_pkg::SGC_IND_SPEED_LACT: begin
                        ind1_nxt[p] = lit_speed ? `SGC_IND_ON : `SGC_IND_OFF;
                        ind0_nxt[p] = lit_lact  ? `SGC_IND_ON : `SGC_IND_OFF;
                    end
                    sgc_pkg::SGC_IND_ACT_LINK: begin
                        ind1_nxt[p] = lit_act   ? `SGC_IND_ON : `SGC_IND_OFF;
                        ind0_nxt[p] = lit_link  ? `SGC_IND_ON : `SGC_IND_OFF;
                    end
                    sgc_pkg::SGC_IND_DUP_LACT: begin
                        ind1_nxt[p] = lit_dup   ? `SGC_IND_ON : `SGC_IND_OFF;
                        ind0_nxt[p] = lit_lact  ? `SGC_IND_ON : `SGC_IND_OFF;
                    end
                    sgc_pkg::SGC_IND_DUP_LINK: begin
                        ind1_nxt[p] = lit_dup   ? `SGC_IND_ON : `SGC_IND_OFF;
                        ind0_nxt[p] = lit_link  ? `SGC_IND_ON : `SGC_IND_OFF;
                    end
                endcase
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            blink_cnt_r <= 32'h0000_0000;
            blink_r     <= 1'b0;
            ind1_r      <= '1;
            ind0_r      <= '1;
        end else if (i_ce) begin
            blink_cnt_r <= blink_cnt_nxt;
            blink_r     <= blink_nxt;
            ind1_r      <= ind1_nxt;
            ind0_r      <= ind0_nxt;
        end
    end

    assign o_port_indicator_one  = ind1_r;
    assign o_port_indicator_zero = ind0_r;

endmodule : sgc_global_ctrl

// ===== verilog/sgc_pkg.sv
/*
 * Types shared by the global control block.
 * Assumes sgc_defines.svh is on the include path.
 */
`include "sgc_defines.svh"

package sgc_pkg;

    typedef enum logic [1:0] {
        SGC_IND_SPEED_LACT  = 2'b00,
        SGC_IND_ACT_LINK    = 2'b01,
        SGC_IND_DUP_LACT    = 2'b10,
        SGC_IND_DUP_LINK    = 2'b11
    } sgc_ind_mode_type;

    typedef enum logic [0:0] {
        SGC_FL_IDLE = 1'b0,
        SGC_FL_BUSY = 1'b1
    } sgc_flush_state_type;

    // Register access request from the SPI management front end
    typedef struct packed {
        logic                      wr;
        logic                      rd;
        logic [`SGC_ADDR_W-1:0]    addr;
        logic [`SGC_DATA_W-1:0]    wdata;
    } sgc_req_type;

    // Per-port status fed in from the port MACs and PHYs
    typedef struct packed {
        logic link;
        logic act;
        logic speed_100;
        logic full_duplex;
    } sgc_port_stat_type;

endpackage : sgc_pkg

// ===== verilog/sgc_regfile.sv
/*
 * Register store for the four control words, with registered read data.
 * Assumes a single synchronous write port and one read port.
 */
`timescale 1ns/1ps
`include "sgc_defines.svh"

module sgc_regfile #(
    parameter int DW = `SGC_DATA_W
) (
    input  wire logic          i_clk_sys,
    input  wire logic          i_reset_n,
    input  wire logic          i_ce,
    input  wire logic [1:0]    i_waddr,
    input  wire logic          i_we,
    input  wire logic [DW-1:0] i_wdata,
    input  wire logic [DW-1:0] i_aux_rst,
    input  wire logic          i_load_aux,
    input  wire logic [1:0]    i_raddr,
    output logic      [DW-1:0] o_rdata,
    output logic      [DW-1:0] o_word0,
    output logic      [DW-1:0] o_word3
);

    logic [DW-1:0] mem_r [4];
    logic [DW-1:0] mem_nxt [4];
    logic [DW-1:0] rdata_r;
    logic [DW-1:0] rdata_nxt;

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            mem_nxt[k] = mem_r[k];
        end
        if (i_we) begin
            mem_nxt[i_waddr] = i_wdata;
        end
        // Strap capture overrides a word 3 write landing in the same cycle
        if (i_load_aux) begin
            mem_nxt[3] = i_aux_rst;
        end
        rdata_nxt = mem_r[i_raddr];
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mem_r[0] <= `SGC_RST_MIB_CTRL;
            mem_r[1] <= `SGC_RST_FTEST_A;
            mem_r[2] <= `SGC_RST_FTEST_B;
            mem_r[3] <= `SGC_RST_CLK_IND;
            rdata_r  <= `SGC_ZERO8;
        end else if (i_ce) begin
            for (int k = 0; k < 4; k++) begin
                mem_r[k] <= mem_nxt[k];
            end
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_word0 = mem_r[0];
    assign o_word3 = mem_r[3];

endmodule : sgc_regfile
